/* File: inc/iap_pkg.sv */
package iap_pkg;

   // ----------------------------------------------------------------
   // Register bus geometry
   // ----------------------------------------------------------------
   localparam int unsigned ADDR_W    = 8;
   localparam int unsigned DATA_W    = 32;
   localparam int unsigned LANE_W    = 8;
   localparam int unsigned MAX_LANES = 4;

   // ----------------------------------------------------------------
   // Register offsets (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [ADDR_W-1:0] OFS_CTRL   = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_PERR   = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_AIS    = 8'h08;

   // ----------------------------------------------------------------
   // Control register fields
   // ----------------------------------------------------------------
   localparam int unsigned CTRL_W          = 5;
   localparam int unsigned CTRL_BYPASS_BIT = 0;
   localparam int unsigned CTRL_MODE_BIT   = 1;
   localparam int unsigned CTRL_INC_MK_BIT = 2;
   localparam int unsigned CTRL_INC_PL_BIT = 3;
   localparam int unsigned CTRL_ODD_BIT    = 4;

   // Four-stream mode after reset, bypass off, even parity.
   localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h02;

endpackage

/* File: src/iap_top.sv */
`timescale 1ns/1ns
// Summary of operation
// - Bypass on: lane alarm flag gives AIS status.
// - Bypass off: all incoming alarm flags ignored.
// - Alarm flag ignored while lane payload inactive.
// - Four-stream mode samples on low-speed clock.
// - Single-stream uses lane 1 on high-speed clock.
// - Lanes 1-4 map to byte lanes upward.
// - Parity over byte, optional marker and payload.
// - Odd check when select high, else even.
module iap_top #(
   parameter int unsigned NUM_LANES = 4
) (
   input  wire logic                                 core_clk,
   input  wire logic                                 resetn,
   input  wire logic [iap_pkg::ADDR_W-1:0]           reg_addr,
   input  wire logic [iap_pkg::DATA_W-1:0]           reg_wdata,
   input  wire logic                                 reg_wr,
   input  wire logic                                 reg_rd,
   output logic      [iap_pkg::DATA_W-1:0]           reg_rdata,
   input  wire logic                                 low_speed_sys_clk,
   input  wire logic                                 high_speed_sys_clk,
   input  wire logic [NUM_LANES*iap_pkg::LANE_W-1:0] in_data_bus,
   input  wire logic [NUM_LANES-1:0]                 in_trib_alarm_flag,
   input  wire logic [NUM_LANES-1:0]                 in_lane_parity,
   input  wire logic [NUM_LANES-1:0]                 in_frame_marker,
   input  wire logic [NUM_LANES-1:0]                 in_payload_active,
   output logic      [NUM_LANES-1:0]                 trib_ais_status,
   output logic      [NUM_LANES-1:0]                 parity_err_pulse
);

   localparam int unsigned BUS_W = NUM_LANES * iap_pkg::LANE_W;
   localparam int unsigned PAD_W = iap_pkg::DATA_W - NUM_LANES;
   localparam int unsigned TOP   = NUM_LANES - 1;

   if (NUM_LANES < 1 || NUM_LANES > iap_pkg::MAX_LANES) begin : g_bad_lanes
      $error("NUM_LANES must lie between 1 and 4.");
   end

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   logic [BUS_W-1:0]     data_s1_ff, data_s2_ff;
   logic [NUM_LANES-1:0] flag_s1_ff, flag_s2_ff;
   logic [NUM_LANES-1:0] par_s1_ff,  par_s2_ff;
   logic [NUM_LANES-1:0] mk_s1_ff,   mk_s2_ff;
   logic [NUM_LANES-1:0] pl_s1_ff,   pl_s2_ff;
   logic [2:0]           lsclk_ff;
   logic [2:0]           high_speed_sys_clk_ff;
   // Lane clocks are sampled like data, so they must run far below core_clk.

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         data_s1_ff <= '0;
         data_s2_ff <= '0;
         flag_s1_ff <= '0;
         flag_s2_ff <= '0;
         par_s1_ff  <= '0;
         par_s2_ff  <= '0;
         mk_s1_ff   <= '0;
         mk_s2_ff   <= '0;
         pl_s1_ff   <= '0;
         pl_s2_ff   <= '0;
         lsclk_ff   <= 3'h0;
         high_speed_sys_clk_ff   <= 3'h0;
      end else begin
         data_s1_ff <= in_data_bus;
         data_s2_ff <= data_s1_ff;
         flag_s1_ff <= in_trib_alarm_flag;
         flag_s2_ff <= flag_s1_ff;
         par_s1_ff  <= in_lane_parity;
         par_s2_ff  <= par_s1_ff;
         mk_s1_ff   <= in_frame_marker;
         mk_s2_ff   <= mk_s1_ff;
         pl_s1_ff   <= in_payload_active;
         pl_s2_ff   <= pl_s1_ff;
         lsclk_ff   <= {lsclk_ff[1:0], low_speed_sys_clk};
         high_speed_sys_clk_ff   <= {high_speed_sys_clk_ff[1:0], high_speed_sys_clk};
      end
   end

   // ----------------------------------------------------------------
   // Control register and decode
   // ----------------------------------------------------------------
   logic [iap_pkg::CTRL_W-1:0] ctrl_ff;
   logic [NUM_LANES-1:0]       perr_sticky_ff;
   logic [NUM_LANES-1:0]       ais_ff;
   logic [NUM_LANES-1:0]       perr_pulse_ff;
   logic [iap_pkg::DATA_W-1:0] rdata_ff;

   wire sel_ctrl = (reg_addr == iap_pkg::OFS_CTRL);
   wire sel_perr = (reg_addr == iap_pkg::OFS_PERR);
   wire sel_ais  = (reg_addr == iap_pkg::OFS_AIS);

   wire ptr_interp_bypass           = ctrl_ff[iap_pkg::CTRL_BYPASS_BIT];
   wire low_rate_lane_mode_sel      = ctrl_ff[iap_pkg::CTRL_MODE_BIT];
   wire parity_include_marker       = ctrl_ff[iap_pkg::CTRL_INC_MK_BIT];
   wire parity_include_payload_flag = ctrl_ff[iap_pkg::CTRL_INC_PL_BIT];
   wire parity_odd_select           = ctrl_ff[iap_pkg::CTRL_ODD_BIT];

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         ctrl_ff <= iap_pkg::CTRL_RESET;
      end else if (reg_wr && sel_ctrl) begin
         ctrl_ff <= reg_wdata[iap_pkg::CTRL_W-1:0];
      end
   end

   // ----------------------------------------------------------------
   // Sampling edge selection
   // ----------------------------------------------------------------
   wire ls_rise    = lsclk_ff[1] & ~lsclk_ff[2];
   wire hs_rise    = high_speed_sys_clk_ff[1] & ~high_speed_sys_clk_ff[2];
   wire sample_stb = low_rate_lane_mode_sel ? ls_rise : hs_rise;

   // ----------------------------------------------------------------
   // Per-lane alarm and parity evaluation
   // ----------------------------------------------------------------
   logic [NUM_LANES-1:0] lane_en;
   logic [NUM_LANES-1:0] lane_ais;
   logic [NUM_LANES-1:0] lane_sum;
   logic [NUM_LANES-1:0] lane_bad;

   for (genvar i = 0; i < NUM_LANES; i++) begin : g_lane
      // Only lane 1 carries the stream in single-stream mode.
      assign lane_en[i]  = low_rate_lane_mode_sel | (i == 0);
      // Outside payload the flag is not looked at and the lane keeps its status.
      assign lane_ais[i] = ptr_interp_bypass & lane_en[i] & (pl_s2_ff[i] ? flag_s2_ff[i] : ais_ff[i]);
      assign lane_sum[i] = (^data_s2_ff[i*iap_pkg::LANE_W +: iap_pkg::LANE_W])
                         ^ (parity_include_marker & mk_s2_ff[i])
                         ^ (parity_include_payload_flag & pl_s2_ff[i])
                         ^ par_s2_ff[i];
      assign lane_bad[i] = lane_en[i] & (lane_sum[i] != parity_odd_select);
   end

   // A parity hit in the same cycle as a software clear wins, so no error is lost.
   wire [NUM_LANES-1:0] perr_clr      = (reg_wr && sel_perr) ? reg_wdata[NUM_LANES-1:0] : '0;
   wire [NUM_LANES-1:0] nxt_perr_hit  = sample_stb ? lane_bad : '0;
   wire [NUM_LANES-1:0] nxt_perr_stky = (perr_sticky_ff & ~perr_clr) | nxt_perr_hit;
   wire [NUM_LANES-1:0] nxt_ais       = sample_stb ? lane_ais : (ptr_interp_bypass ? ais_ff : '0);

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         ais_ff         <= '0;
         perr_pulse_ff  <= '0;
         perr_sticky_ff <= '0;
      end else begin
         ais_ff         <= nxt_ais;
         perr_pulse_ff  <= nxt_perr_hit;
         perr_sticky_ff <= nxt_perr_stky;
      end
   end

   // ----------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------
   wire [iap_pkg::DATA_W-1:0] rd_ctrl = {{(iap_pkg::DATA_W-iap_pkg::CTRL_W){1'b0}}, ctrl_ff};
   wire [iap_pkg::DATA_W-1:0] rd_perr = {{PAD_W{1'b0}}, perr_sticky_ff};
   wire [iap_pkg::DATA_W-1:0] rd_ais  = {{PAD_W{1'b0}}, ais_ff};
   // Read data stand one cycle after the strobe and are zero otherwise.
   wire [iap_pkg::DATA_W-1:0] nxt_rdata = !reg_rd  ? '0 :
                                          sel_ctrl ? rd_ctrl :
                                          sel_perr ? rd_perr :
                                          sel_ais  ? rd_ais  : '0;

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         rdata_ff <= '0;
      end else begin
         rdata_ff <= nxt_rdata;
      end
   end

   assign reg_rdata        = rdata_ff;
   assign trib_ais_status  = ais_ff;
   assign parity_err_pulse = perr_pulse_ff;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   property p_ais_follow;
      @(posedge core_clk) disable iff (!resetn)
      (sample_stb && ptr_interp_bypass && pl_s2_ff[0] && flag_s2_ff[0]) |=> ais_ff[0];
   endproperty
   a_ais_follow: assert property (p_ais_follow) else $error("AIS status missed a set flag.");

   property p_no_bypass;
      @(posedge core_clk) disable iff (!resetn)
      (!ptr_interp_bypass && !(reg_wr && sel_ctrl)) |=> (ais_ff == '0);
   endproperty
   a_no_bypass: assert property (p_no_bypass) else $error("AIS status set without bypass.");

   property p_pl_low;
      @(posedge core_clk) disable iff (!resetn)
      (sample_stb && ptr_interp_bypass && low_rate_lane_mode_sel && !pl_s2_ff[TOP]) |=> $stable(ais_ff[TOP]);
   endproperty
   a_pl_low: assert property (p_pl_low) else $error("AIS taken while payload inactive.");

   property p_four_edge;
      @(posedge core_clk) disable iff (!resetn)
      (low_rate_lane_mode_sel && $rose(lsclk_ff[2])) |-> $past(sample_stb);
   endproperty
   a_four_edge: assert property (p_four_edge) else $error("Low-speed edge not sampled.");

   property p_single_lanes;
      @(posedge core_clk) disable iff (!resetn)
      (sample_stb && !low_rate_lane_mode_sel) |-> (hs_rise && (lane_bad[TOP:0] >> 1) == '0) ##1 (ais_ff >> 1) == '0;
   endproperty
   a_single_lanes: assert property (p_single_lanes) else $error("Upper lanes used in single-stream.");

   property p_top_lane_parity;
      @(posedge core_clk) disable iff (!resetn)
      (sample_stb && low_rate_lane_mode_sel && !parity_include_marker && !parity_include_payload_flag)
         |=> perr_pulse_ff[TOP] ==
             ((^$past(data_s2_ff[BUS_W-1 -: iap_pkg::LANE_W]) ^ $past(par_s2_ff[TOP])) != $past(parity_odd_select));
   endproperty
   a_top_lane_parity: assert property (p_top_lane_parity) else $error("Top lane parity mismatch.");

   property p_marker_incl;
      @(posedge core_clk) disable iff (!resetn)
      (sample_stb && parity_include_marker && !parity_include_payload_flag && !parity_odd_select)
         |=> perr_pulse_ff[0] == (^$past(data_s2_ff[7:0]) ^ $past(mk_s2_ff[0]) ^ $past(par_s2_ff[0]));
   endproperty
   a_marker_incl: assert property (p_marker_incl) else $error("Marker not in lane 1 parity.");

   property p_odd_sense;
      @(posedge core_clk) disable iff (!resetn)
      (sample_stb && parity_odd_select && !parity_include_marker && !parity_include_payload_flag)
         |=> perr_pulse_ff[0] == !(^$past(data_s2_ff[7:0]) ^ $past(par_s2_ff[0]));
   endproperty
   a_odd_sense: assert property (p_odd_sense) else $error("Odd parity check wrong.");

   property p_sticky;
      @(posedge core_clk) disable iff (!resetn)
      perr_pulse_ff[0] |-> perr_sticky_ff[0] ##1 (perr_sticky_ff[0] || $past(perr_clr[0]));
   endproperty
   a_sticky: assert property (p_sticky) else $error("Parity error not held for software.");

   property p_ais_hold;
      @(posedge core_clk) disable iff (!resetn)
      (!sample_stb && ptr_interp_bypass) |=> $stable(ais_ff);
   endproperty
   a_ais_hold: assert property (p_ais_hold) else $error("AIS status moved between samples.");

   property p_ais_clear;
      @(posedge core_clk) disable iff (!resetn)
      (sample_stb && ptr_interp_bypass && pl_s2_ff[0] && !flag_s2_ff[0]) |=> !ais_ff[0];
   endproperty
   a_ais_clear: assert property (p_ais_clear) else $error("AIS status kept after flag went low.");

   property p_lane_map;
      @(posedge core_clk) disable iff (!resetn)
      (sample_stb && ptr_interp_bypass && low_rate_lane_mode_sel && pl_s2_ff[TOP])
         |=> ais_ff[TOP] == $past(flag_s2_ff[TOP]);
   endproperty
   a_lane_map: assert property (p_lane_map) else $error("Top lane flag not on its own status bit.");

   property p_hs_edge;
      @(posedge core_clk) disable iff (!resetn)
      (!low_rate_lane_mode_sel && $rose(high_speed_sys_clk_ff[2])) |-> $past(sample_stb);
   endproperty
   a_hs_edge: assert property (p_hs_edge) else $error("High-speed edge not sampled.");

   property p_pl_incl;
      @(posedge core_clk) disable iff (!resetn)
      (sample_stb && parity_include_payload_flag && !parity_include_marker && !parity_odd_select)
         |=> perr_pulse_ff[0] == (^$past(data_s2_ff[7:0]) ^ $past(pl_s2_ff[0]) ^ $past(par_s2_ff[0]));
   endproperty
   a_pl_incl: assert property (p_pl_incl) else $error("Payload flag not in lane 1 parity.");

   property p_even_sense;
      @(posedge core_clk) disable iff (!resetn)
      (sample_stb && !parity_odd_select && !parity_include_marker && !parity_include_payload_flag)
         |=> perr_pulse_ff[0] == (^$past(data_s2_ff[7:0]) ^ $past(par_s2_ff[0]));
   endproperty
   a_even_sense: assert property (p_even_sense) else $error("Even parity check wrong.");

   property p_top_all_incl;
      @(posedge core_clk) disable iff (!resetn)
      (sample_stb && low_rate_lane_mode_sel && parity_include_marker && parity_include_payload_flag
       && parity_odd_select)
         |=> perr_pulse_ff[TOP] == !(^$past(data_s2_ff[BUS_W-1 -: iap_pkg::LANE_W]) ^ $past(mk_s2_ff[TOP])
                                    ^ $past(pl_s2_ff[TOP]) ^ $past(par_s2_ff[TOP]));
   endproperty
   a_top_all_incl: assert property (p_top_all_incl) else $error("Top lane full parity wrong.");

   property p_no_pulse_idle;
      @(posedge core_clk) disable iff (!resetn)
      !sample_stb |=> perr_pulse_ff == '0;
   endproperty
   a_no_pulse_idle: assert property (p_no_pulse_idle) else $error("Parity pulse without a sample.");

   property p_upper_quiet;
      @(posedge core_clk) disable iff (!resetn)
      (sample_stb && !low_rate_lane_mode_sel) |=> (perr_pulse_ff >> 1) == '0;
   endproperty
   a_upper_quiet: assert property (p_upper_quiet) else $error("Upper lane parity in single-stream.");

   property p_perr_clear;
      @(posedge core_clk) disable iff (!resetn)
      (perr_clr[0] && !nxt_perr_hit[0]) |=> !perr_sticky_ff[0];
   endproperty
   a_perr_clear: assert property (p_perr_clear) else $error("Parity error not cleared.");

   property p_perr_set;
      @(posedge core_clk) disable iff (!resetn)
      nxt_perr_hit[TOP] |=> perr_sticky_ff[TOP];
   endproperty
   a_perr_set: assert property (p_perr_set) else $error("Top lane parity error not recorded.");

endmodule

/* File: sim/iap_lane_model.sv */
`timescale 1ns/1ns
// ------------------------------------------------------------
// Upstream lane source: drives byte lanes, flags and lane clocks.
// ------------------------------------------------------------
module iap_lane_model (
   input  wire logic        core_clk,
   output logic             low_speed_sys_clk,
   output logic             high_speed_sys_clk,
   output logic [31:0]      in_data_bus,
   output logic [3:0]       in_trib_alarm_flag,
   output logic [3:0]       in_lane_parity,
   output logic [3:0]       in_frame_marker,
   output logic [3:0]       in_payload_active
);
   initial begin
      {low_speed_sys_clk, high_speed_sys_clk} = 2'h0;
      {in_data_bus, in_trib_alarm_flag, in_lane_parity, in_frame_marker, in_payload_active} = '0;
   end
   // Bad marks lanes whose parity bit is sent wrong on purpose.
   task automatic send(input logic [4:0] c, input logic [31:0] d, input logic [3:0] ais, mk, pl, bad);
      logic [3:0] lm;
      lm = c[1] ? 4'hf : 4'h1;
      @(posedge core_clk);
      in_data_bus        <= d;
      in_trib_alarm_flag <= ais & lm;
      in_frame_marker    <= mk & lm;
      in_payload_active  <= pl & lm;
      for (int i = 0; i < 4; i++) begin
         in_lane_parity[i] <= lm[i] & (bad[i] ^ c[4] ^ (^d[8*i+:8]) ^ (mk[i] & c[2]) ^ (pl[i] & c[3]));
      end
      repeat (2) @(posedge core_clk);
      if (c[1]) low_speed_sys_clk <= 1'b1;
      else high_speed_sys_clk <= 1'b1;
   endtask
   // The bus is no longer held after the clock falls, so it shows the inverse.
   task automatic release_lanes();
      @(posedge core_clk);
      low_speed_sys_clk  <= 1'b0;
      high_speed_sys_clk <= 1'b0;
      repeat (2) @(posedge core_clk);
      in_data_bus <= ~in_data_bus;
   endtask
endmodule

/* File: sim/testbench.sv */
`timescale 1ns/1ns
// ------------------------------------------------------------
// Self-checking bench for the lane alarm and parity block.
// ------------------------------------------------------------
module testbench;
   logic        core_clk  = 1'b0;
   logic        resetn    = 1'b0;
   logic        reg_wr    = 1'b0;
   logic        reg_rd    = 1'b0;
   logic [7:0]  reg_addr  = 8'h00;
   logic [31:0] reg_wdata = 32'h0000_0000;
   logic [31:0] reg_rdata, in_data_bus, d;
   logic        low_speed_sys_clk, high_speed_sys_clk;
   logic [3:0]  in_trib_alarm_flag, in_lane_parity, in_frame_marker, in_payload_active;
   logic [3:0]  trib_ais_status, parity_err_pulse, ais, mk, pl, bad, lm, exp_err;
   logic [3:0]  exp_ais = 4'h0;
   logic [4:0]  ctrl;
   int          err_total = 0;
   int          n_checks = 0;
   always #50 core_clk = ~core_clk;
   iap_top #(.NUM_LANES(4)) iap_top_inst (.core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .low_speed_sys_clk(low_speed_sys_clk), .high_speed_sys_clk(high_speed_sys_clk), .in_data_bus(in_data_bus),
      .in_trib_alarm_flag(in_trib_alarm_flag), .in_lane_parity(in_lane_parity), .in_frame_marker(in_frame_marker),
      .in_payload_active(in_payload_active), .trib_ais_status(trib_ais_status),
      .parity_err_pulse(parity_err_pulse));
   iap_lane_model iap_lane_model_inst (.core_clk(core_clk), .low_speed_sys_clk(low_speed_sys_clk),
      .high_speed_sys_clk(high_speed_sys_clk), .in_data_bus(in_data_bus), .in_trib_alarm_flag(in_trib_alarm_flag),
      .in_lane_parity(in_lane_parity), .in_frame_marker(in_frame_marker), .in_payload_active(in_payload_active));
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch at %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge core_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= v;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge core_clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 cmp(reg_rdata, exp);
   endtask
   // Parity check outcome per lane from what stands on the lane pins.
   function automatic logic [3:0] f_err(logic [4:0] c, logic [31:0] b, logic [3:0] p, m, a, l);
      for (int i = 0; i < 4; i++) begin
         f_err[i] = l[i] & ((p[i] ^ (^b[8*i+:8]) ^ (m[i] & c[2]) ^ (a[i] & c[3])) != c[4]);
      end
   endfunction
   task automatic test_done();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      void'($urandom(32'hf069_59ca));
      repeat (6) @(posedge core_clk);
      resetn <= 1'b1;
      rd(iap_pkg::OFS_CTRL, 32'(iap_pkg::CTRL_RESET));
      rd(8'h0c, 32'h0000_0000);
      wr(8'h0c, 32'hffff_ffff);
      rd(iap_pkg::OFS_CTRL, 32'(iap_pkg::CTRL_RESET));
      for (int n = 0; n < 48; n++) begin
         ctrl = 5'($urandom);
         d = $urandom;
         {ais, mk, pl, bad} = 16'($urandom);
         if (n < 2) begin
            ctrl = n ? 5'h03 : 5'h02;
            {ais, pl} = 8'hff;
         end
         lm = ctrl[1] ? 4'hf : 4'h1;
         wr(iap_pkg::OFS_CTRL, {27'h0, ctrl});
         if (!ctrl[0]) exp_ais = 4'h0;
         iap_lane_model_inst.send(ctrl, d, ais, mk, pl, bad);
         repeat (3) @(posedge core_clk);
         #1;
         for (int i = 0; i < 4; i++) begin
            if (!lm[i] || !ctrl[0]) exp_ais[i] = 1'b0;
            else if (pl[i]) exp_ais[i] = ais[i];
         end
         exp_err = f_err(ctrl, in_data_bus, in_lane_parity, in_frame_marker, in_payload_active, lm);
         cmp(trib_ais_status, exp_ais);
         cmp(parity_err_pulse, exp_err);
         iap_lane_model_inst.release_lanes();
         rd(iap_pkg::OFS_PERR, exp_err);
         rd(iap_pkg::OFS_AIS, exp_ais);
         rd(iap_pkg::OFS_CTRL, ctrl);
         wr(iap_pkg::OFS_PERR, 32'h0000_000f);
         $display("test %0d done ctrl %h", n, ctrl);
      end
      test_done();
   end
endmodule
